//--- hw/atrs_defs.svh
/*
 Constants for the antenna tuner relay sequencer: register offsets,
 control field positions, reset values and timing counts.
 Assumes a 200 MHz system clock and a 32-bit APB register bus.
*/
`ifndef ATRS_DEFS_SVH
`define ATRS_DEFS_SVH
// Behaviour
// RULE1: Selector ground pulse latches retune until max-reverse
// RULE2: Retune entry clears shunt, sets homing, auto-keying
// RULE3: Auto-keying asserts transmitter keying output
// RULE4: Radio-silence mode: keying from error line only; code keys only on operator key and RF together with the error
// RULE5: RF during homing unbalances phasing discriminator
// RULE6: Any error input asserts combined error line
// RULE7: Max-reverse set by homing+error, held conditionally
// RULE8: Max-reverse releases retune
// RULE9: Keying held by error, bridged across handover
// RULE10: Homing held by closed switch, drives centre
// RULE11: Switch opening ends homing, loading error rules
// RULE12: Switch reclosing after homing brakes loading motor
// RULE13: Max-reverse without select runs inductor to minimum
// RULE14: Inductor minimum selects capacitor, runs to minimum
// RULE15: Both minimum: min-reverse, deselect, inductor six turns
// RULE16: Six-turn point selects capacitor toward maximum
// RULE17: Capacitor maximum deselects, inductor runs to maximum
// RULE18: Inductor or loading maximum switches shunt in
// RULE19: Inductor maximum with error restarts max-reverse
// RULE20: Inductive error clears max, capacitive clears min
// RULE21: No error clears auto-keying and keying output
// RULE22: Thirty second timeout removes motor and keying drive
// RULE23: Released or deselected motor is braked
// RULE24: Error or reverse state sets series motor direction
// RULE25: Synchronised inputs, clocked flags, clearable state
`define ATRS_CLK_MHZ     200
`define ATRS_BRIDGE_NS   1000
`define ATRS_BRIDGE_CYC  ((`ATRS_BRIDGE_NS * `ATRS_CLK_MHZ + 999) / 1000)
`define ATRS_TMO_S       30
`define ATRS_TMO_CYC     (`ATRS_TMO_S * 64'd1000000 * `ATRS_CLK_MHZ)
`define ATRS_OFF_CTRL    12'h000
`define ATRS_OFF_STAT    12'h004
`define ATRS_OFF_INPUT   12'h008
`define ATRS_CTRL_SILENT 0
`define ATRS_CTRL_RETUNE 1
`define ATRS_CTRL_CLEAR  2
`define ATRS_CTRL_RST    1'h0
`define ATRS_SYNC_RST    13'h1000
`endif

//--- hw/atrs_pkg.sv
/*
 Types for the antenna tuner relay sequencer.
 Assumes atrs_defs.svh holds all numeric constants.
*/
package atrs_pkg;
    // Register selected by an APB address
    typedef enum logic [1:0] {
        ATRS_R_CTRL, ATRS_R_STAT, ATRS_R_INPUT, ATRS_R_NONE
    } atrs_reg_t;
    // Command to one series-element motor
    typedef enum logic [1:0] {
        ATRS_M_STOP, ATRS_M_MIN, ATRS_M_MAX
    } atrs_mcmd_t;
endpackage

//--- hw/atrs_top.sv
/*
 Antenna tuner relay sequencer: each relay of the tuning cycle is a
 clocked flag; motors, keying and shunt outputs are registered.
 Assumes switch and error inputs are level signals from the tuner
 and a zero-wait APB master on the same clock.
*/
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "atrs_defs.svh"
module atrs_top
    import atrs_pkg::*;
#(
    parameter logic [35:0] TMO_CYC    = 36'(`ATRS_TMO_CYC),
    parameter int          BRIDGE_CYC = `ATRS_BRIDGE_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        retune_n,
    input  wire logic        rf_present,
    input  wire logic        tx_key_req,
    input  wire logic        cap_err,
    input  wire logic        ind_err,
    input  wire logic        load_err,
    input  wire logic        ctap_closed,
    input  wire logic        ind_at_min,
    input  wire logic        ind_at_six,
    input  wire logic        ind_at_max,
    input  wire logic        cap_at_min,
    input  wire logic        cap_at_max,
    input  wire logic        load_at_max,
    output logic             tx_key,
    output logic             cap_unbal,
    output logic             err_line,
    output logic             home_drive,
    output logic             load_brake,
    output logic             shunt_on,
    output logic             ind_to_min,
    output logic             ind_to_max,
    output logic             ind_brake,
    output logic             cap_to_min,
    output logic             cap_to_max,
    output logic             cap_brake
);
    // Refuse values the counters cannot hold
    if (TMO_CYC == 36'h0 || BRIDGE_CYC < 1 || BRIDGE_CYC > 255) begin : g_chk
        $error("atrs_top: bad timing parameter");
    end

    logic [12:0] raw, s1_r, s2_r;
    logic rt_n, rf, key, cerr, ierr, lerr, ctap;
    logic imin, isix, imax, cmin, cmax, lmax;
    logic retune_r, homing_r, autokey_r, maxrev_r, minrev_r;
    logic elsel_r, shunt_r, homed_r, tmo_r;
    logic retune_nxt, homing_nxt, autokey_nxt, maxrev_nxt, minrev_nxt;
    logic elsel_nxt, shunt_nxt, tmo_nxt;
    logic err, entry, ak_set, mx_set, mn_set, bridging, clr;
    logic silent_r, sw_rt_r, sw_clr_r;
    logic [7:0]  bridge_r;
    logic [35:0] tcnt_r;
    logic tmin, tmax;
    atrs_mcmd_t icmd, ccmd;
    atrs_reg_t  sel;

    function automatic atrs_reg_t decode(input logic [11:0] a);
        if (a == `ATRS_OFF_CTRL) return ATRS_R_CTRL;
        else if (a == `ATRS_OFF_STAT) return ATRS_R_STAT;
        else if (a == `ATRS_OFF_INPUT) return ATRS_R_INPUT;
        else return ATRS_R_NONE;
    endfunction

    // Direction for one motor; stops at its limit like the limit switches
    function automatic atrs_mcmd_t motor_cmd(input logic act, input logic to_mn,
                                             input logic to_mx, input logic at_mn,
                                             input logic at_mx);
        if (!act || (to_mn && to_mx)) return ATRS_M_STOP;
        else if (to_mn && !at_mn) return ATRS_M_MIN;
        else if (to_mx && !at_mx) return ATRS_M_MAX;
        else return ATRS_M_STOP;
    endfunction

    // Two-stage synchroniser on every tuner input
    assign raw = {retune_n, rf_present, tx_key_req, cap_err, ind_err, load_err,
                  ctap_closed, ind_at_min, ind_at_six, ind_at_max, cap_at_min,
                  cap_at_max, load_at_max};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= `ATRS_SYNC_RST;
            s2_r <= `ATRS_SYNC_RST;
        end else begin
            s1_r <= raw; // RULE25
            s2_r <= s1_r;
        end
    end
    assign {rt_n, rf, key, cerr, ierr, lerr, ctap, imin, isix, imax, cmin, cmax,
            lmax} = s2_r;

    // APB slave: zero wait states, unmapped addresses answer with an error
    assign sel     = decode(paddr);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & (sel == ATRS_R_NONE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            silent_r <= `ATRS_CTRL_RST;
            sw_rt_r  <= 1'b0;
            sw_clr_r <= 1'b0;
        end else begin
            sw_rt_r  <= 1'b0;
            sw_clr_r <= 1'b0;
            if (psel && penable && pwrite && sel == ATRS_R_CTRL) begin
                silent_r <= pwdata[`ATRS_CTRL_SILENT];
                sw_rt_r  <= pwdata[`ATRS_CTRL_RETUNE];
                sw_clr_r <= pwdata[`ATRS_CTRL_CLEAR];
            end
        end
    end

    // Read data is captured in the setup cycle so it leaves a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            if (sel == ATRS_R_CTRL) prdata <= {31'h0, silent_r};
            else if (sel == ATRS_R_STAT)
                prdata <= {22'h0, bridging, tmo_r, homed_r, shunt_r, elsel_r,
                           minrev_r, maxrev_r, autokey_r, homing_r, retune_r};
            else if (sel == ATRS_R_INPUT) prdata <= {19'h0, s2_r};
            else prdata <= 32'h0;
        end
    end

    // Sequencing conditions
    assign clr   = sw_clr_r; // RULE25
    assign err   = cerr | ierr | lerr; // RULE6
    assign retune_nxt = ~clr & (~rt_n | sw_rt_r | retune_r) & ~maxrev_r; // RULE1 RULE8
    assign entry = retune_nxt & ~retune_r;
    // Radio silence: no keying at retune, only on operator key with RF
    assign ak_set = silent_r ? (key & rf & err) : entry; // RULE4
    assign autokey_nxt = ~clr & ~tmo_r & (ak_set | autokey_r & (err // RULE9 RULE21
                         | (~silent_r & (retune_r | bridging))));
    assign homing_nxt = ~clr & (entry | (homing_r & ctap & ~cerr)); // RULE2 RULE10 RULE11
    assign mx_set = (homing_r & err) | (imax & err & ~elsel_r); // RULE7 RULE19
    assign maxrev_nxt = ~clr & ~tmo_r & err & ~ierr // RULE20
                        & (mx_set | (maxrev_r & ~minrev_r)); // RULE7
    assign mn_set = maxrev_r & elsel_r & imin & cmin; // RULE15
    assign minrev_nxt = ~clr & ~tmo_r & err & ~cerr & ~(imax & ~elsel_r) // RULE20
                        & (mn_set | minrev_r); // RULE15
    assign shunt_nxt = ~clr & ~entry & (imax | lmax | (shunt_r & ~retune_r)); // RULE18 RULE2
    assign tmo_nxt = ~clr & ~entry & (tmo_r
                     | (autokey_r & err & tcnt_r == TMO_CYC - 36'h1)); // RULE22

    // Element select walks the mechanical search cycle
    always_comb begin
        if (clr || mn_set) elsel_nxt = 1'b0; // RULE15
        else if (maxrev_r && !minrev_r && !elsel_r && imin) elsel_nxt = 1'b1; // RULE14
        else if (minrev_r && !elsel_r && isix && !cmax) elsel_nxt = 1'b1; // RULE16
        else if (minrev_r && elsel_r && cmax) elsel_nxt = 1'b0; // RULE17
        else elsel_nxt = elsel_r;
    end

    // Relay flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            retune_r  <= 1'b0;
            homing_r  <= 1'b0;
            autokey_r <= 1'b0;
            maxrev_r  <= 1'b0;
            minrev_r  <= 1'b0;
            elsel_r   <= 1'b0;
            shunt_r   <= 1'b0;
            tmo_r     <= 1'b0;
        end else begin
            retune_r  <= retune_nxt;
            homing_r  <= homing_nxt;
            autokey_r <= autokey_nxt;
            maxrev_r  <= maxrev_nxt;
            minrev_r  <= minrev_nxt;
            elsel_r   <= elsel_nxt;
            shunt_r   <= shunt_nxt;
            tmo_r     <= tmo_nxt;
        end
    end

    // Remembers that homing has finished, arming the loading brake
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) homed_r <= 1'b0;
        else if (clr || entry) homed_r <= 1'b0;
        else if (homing_r && !homing_nxt) homed_r <= 1'b1; // RULE11
    end

    // Handover bridge keeps keying up while retune drops out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) bridge_r <= 8'h0;
        else if (retune_r && !retune_nxt) bridge_r <= 8'(BRIDGE_CYC); // RULE9
        else if (bridge_r != 8'h0) bridge_r <= bridge_r - 8'h1;
    end
    assign bridging = bridge_r != 8'h0;

    // Tuning timer runs only while keyed with error present
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) tcnt_r <= 36'h0;
        else if (!(autokey_r && err) || tmo_r) tcnt_r <= 36'h0;
        else tcnt_r <= tcnt_r + 36'h1; // RULE22
    end

    // Series motor directions; timeout removes all drive
    assign tmin = ~tmo_r & (ierr | maxrev_r); // RULE24 RULE13
    assign tmax = ~tmo_r & (cerr | minrev_r); // RULE24
    assign icmd = motor_cmd(~elsel_r, tmin, tmax, imin, imax); // RULE13 RULE15
    assign ccmd = motor_cmd(elsel_r, tmin, tmax, cmin, cmax); // RULE14 RULE16

    // Registered outputs; a motor that stops or is deselected stays braked
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_key     <= 1'b0;
            cap_unbal  <= 1'b0;
            err_line   <= 1'b0;
            home_drive <= 1'b0;
            load_brake <= 1'b0;
            shunt_on   <= 1'b0;
            ind_to_min <= 1'b0;
            ind_to_max <= 1'b0;
            ind_brake  <= 1'b0;
            cap_to_min <= 1'b0;
            cap_to_max <= 1'b0;
            cap_brake  <= 1'b0;
        end else begin
            tx_key     <= autokey_nxt; // RULE3
            cap_unbal  <= homing_nxt & rf; // RULE5
            err_line   <= err; // RULE6
            home_drive <= homing_nxt & ~tmo_r; // RULE10
            load_brake <= homed_r & ~homing_r & ctap & (cerr | maxrev_r); // RULE12
            shunt_on   <= shunt_nxt; // RULE18
            ind_to_min <= icmd == ATRS_M_MIN;
            ind_to_max <= icmd == ATRS_M_MAX;
            cap_to_min <= ccmd == ATRS_M_MIN;
            cap_to_max <= ccmd == ATRS_M_MAX;
            ind_brake  <= icmd == ATRS_M_STOP
                          & (ind_brake | ind_to_min | ind_to_max); // RULE23
            cap_brake  <= ccmd == ATRS_M_STOP
                          & (cap_brake | cap_to_min | cap_to_max); // RULE23
        end
    end

    // Checks on the sequence
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_retune_latch: assert property ( // RULE1
        retune_r && !maxrev_r && !clr |=> retune_r)
        else $error("retune dropped without max-reverse");
    chk_retune_entry: assert property ( // RULE2
        entry && !silent_r && !tmo_r && !clr |=> homing_r && !shunt_r && autokey_r)
        else $error("retune entry did not home and key");
    chk_key_output: assert property ( // RULE3
        ##1 tx_key == autokey_r)
        else $error("keying output differs from auto-keying");
    chk_silent_key: assert property ( // RULE4
        silent_r && !autokey_r && !(key && rf && err) |=> !autokey_r)
        else $error("silent mode keyed without operator and rf");
    chk_unbal_cause: assert property ( // RULE5
        cap_unbal |-> $past(rf) && homing_r)
        else $error("unbalance without rf during homing");
    chk_err_line: assert property ( // RULE6
        (cerr || ierr || lerr) |=> err_line)
        else $error("error line missed an error input");
    chk_maxrev_hold: assert property ( // RULE7
        maxrev_r |-> $past(err) && !$past(ierr))
        else $error("max-reverse held without cause");
    chk_retune_release: assert property ( // RULE8
        maxrev_r |=> !retune_r)
        else $error("retune kept after max-reverse");
    chk_bridge_hold: assert property ( // RULE9
        $fell(retune_r) && !silent_r && !tmo_r && !clr && !$past(clr) && $past(autokey_r)
        |-> autokey_r ##1 (autokey_r || tmo_r || clr || $past(clr)))
        else $error("keying dropped during handover");
    chk_homing_end: assert property ( // RULE10
        homing_r && !(ctap && !cerr) && !entry |=> !homing_r && !home_drive)
        else $error("homing held with switch open");
    chk_unkey: assert property ( // RULE21
        autokey_r && !err && !retune_r && !bridging && !ak_set |=> !autokey_r ##0 !tx_key)
        else $error("keying held with no error");
    chk_timeout_drive: assert property ( // RULE22
        tmo_r |=> !ind_to_min && !ind_to_max && !cap_to_min && !cap_to_max && !tx_key)
        else $error("drive present after timeout");
    chk_inductor_min: assert property ( // RULE14
        maxrev_r && !minrev_r && !elsel_r && imin && !clr |=> elsel_r)
        else $error("no transfer to capacitor at inductor minimum");
    chk_maxrev_set: assert property ( // RULE7
        homing_r && err && !ierr && !clr && !tmo_r |=> maxrev_r)
        else $error("max-reverse not set by homing with error");
    chk_homed_arm: assert property ( // RULE11
        homing_r && !homing_nxt && !clr |=> homed_r && !home_drive)
        else $error("homing end not recorded");
    chk_load_brake: assert property ( // RULE12
        homed_r && !homing_r && ctap && (cerr || maxrev_r) |=> load_brake)
        else $error("loading motor not braked on reclose");
    chk_ind_to_min: assert property ( // RULE13
        maxrev_r && !minrev_r && !cerr && !elsel_r && !imin && !tmo_r |=> ind_to_min)
        else $error("inductor not run toward minimum");
    chk_cap_to_min: assert property ( // RULE14
        maxrev_r && !minrev_r && !cerr && elsel_r && !cmin && !tmo_r |=> cap_to_min)
        else $error("capacitor not run toward minimum");
    chk_min_reverse: assert property ( // RULE15
        mn_set && err && !cerr && !clr && !tmo_r |=> minrev_r && !elsel_r)
        else $error("both minimums did not set min-reverse");
    chk_six_select: assert property ( // RULE16
        minrev_r && !elsel_r && isix && !cmax && !clr |=> elsel_r)
        else $error("six-turn point did not select capacitor");
    chk_cap_max_drop: assert property ( // RULE17
        minrev_r && elsel_r && cmax |=> !elsel_r)
        else $error("capacitor maximum did not release select");
    chk_shunt_set: assert property ( // RULE18
        (imax || lmax) && !clr && !entry |=> shunt_r && shunt_on)
        else $error("shunt not switched in at maximum");
    chk_restart: assert property ( // RULE19
        imax && err && !ierr && !elsel_r && !clr && !tmo_r |=> maxrev_r && !minrev_r)
        else $error("inductor maximum did not restart search");
    chk_ind_err_clear: assert property ( // RULE20
        ierr |=> !maxrev_r)
        else $error("inductive error left max-reverse set");
    chk_cap_err_clear: assert property ( // RULE20
        cerr |=> !minrev_r)
        else $error("capacitive error left min-reverse set");
    chk_timer_expiry: assert property ( // RULE22
        autokey_r && err && !clr && !entry && tcnt_r == TMO_CYC - 36'h1 |=> tmo_r)
        else $error("tuning timer did not expire");
    chk_brake_stop: assert property ( // RULE23
        (ind_to_min || ind_to_max) && icmd == ATRS_M_STOP |=> ind_brake)
        else $error("stopped inductor motor not braked");
    chk_clear_all: assert property ( // RULE25
        clr |=> !retune_r && !homing_r && !autokey_r && !maxrev_r && !minrev_r && !shunt_r)
        else $error("clear left a flag set");

    cov_retune: cover property (entry ##[1:1000] maxrev_r);
    cov_min_reverse: cover property (mn_set);
    cov_timeout: cover property ($rose(tmo_r));
    cov_tuned: cover property ($fell(autokey_r) && !tmo_r);
    cov_load_brake: cover property ($rose(load_brake));
endmodule // atrs_top

//--- test/atrs_tuner_model.sv
/*
 Far-side model: inductor, capacitor and loading transformer positions
 with their limit switches, moved by the sequencer's motor outputs.
 Assumes the sequencer's clock and reset; errors come from the bench.
*/
`timescale 1ns/1ps
module atrs_tuner_model #(
    parameter int STEP  = 2,
    parameter int LSTEP = 8
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic ind_to_min,
    input  wire logic ind_to_max,
    input  wire logic cap_to_min,
    input  wire logic cap_to_max,
    input  wire logic home_drive,
    output logic      ctap_closed,
    output logic      ind_at_min,
    output logic      ind_at_six,
    output logic      ind_at_max,
    output logic      cap_at_min,
    output logic      cap_at_max,
    output logic      load_at_max
);
    logic [7:0] ind_pos, cap_pos, load_pos;
    logic [7:0] div;
    // Motors creep one notch per step; a motor asked both ways stays put
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ind_pos  <= 8'h08;
            cap_pos  <= 8'h05;
            load_pos <= 8'h05;
            div      <= 8'h00;
        end else begin
            div <= div + 8'h01;
            if (div % STEP == 0) begin
                if (ind_to_min && !ind_to_max && ind_pos != 8'h00) ind_pos <= ind_pos - 8'h01;
                if (ind_to_max && !ind_to_min && ind_pos != 8'h0C) ind_pos <= ind_pos + 8'h01;
                if (cap_to_min && !cap_to_max && cap_pos != 8'h00) cap_pos <= cap_pos - 8'h01;
                if (cap_to_max && !cap_to_min && cap_pos != 8'h08) cap_pos <= cap_pos + 8'h01;
            end
            // Homing overlaps the first inductor run but ends before both minimums;
            // afterwards the loading motor backs off centre tap once home drive drops, so the switch recloses
            if (div % LSTEP == 0 && home_drive && load_pos != 8'h02) load_pos <= load_pos - 8'h01;
            else if (div % LSTEP == 0 && !home_drive && load_pos == 8'h02) load_pos <= 8'h03;
        end
    end
    // Switch levels; the centre-tap switch opens only at centre tap
    assign ctap_closed = (load_pos != 8'h02);
    assign load_at_max = (load_pos == 8'h07);
    assign ind_at_min  = (ind_pos == 8'h00);
    assign ind_at_six  = (ind_pos == 8'h06);
    assign ind_at_max  = (ind_pos == 8'h0C);
    assign cap_at_min  = (cap_pos == 8'h00);
    assign cap_at_max  = (cap_pos == 8'h08);
endmodule // atrs_tuner_model

//--- test/tb_antenna_tuner_relay_sequencer.sv
/*
 Self-checking bench for the relay sequencer: APB master, error
 stimulus and a tuner model. Assumes shortened timeout and bridge.
*/
`timescale 1ns/1ps
module tb_antenna_tuner_relay_sequencer;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        retune_n, rf_present, tx_key_req, cap_err, ind_err, load_err;
    logic        ctap_closed, ind_at_min, ind_at_six, ind_at_max, cap_at_min;
    logic        cap_at_max, load_at_max, tx_key, cap_unbal, err_line, home_drive;
    logic        load_brake, shunt_on, ind_to_min, ind_to_max, ind_brake;
    logic        cap_to_min, cap_to_max, cap_brake;
    logic [2:0]  e;
    int          err_total, n_checks;
    time         t0;
    atrs_top #(.TMO_CYC(36'h7D0), .BRIDGE_CYC(4)) i_atrs_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .retune_n(retune_n), .rf_present(rf_present),
        .tx_key_req(tx_key_req), .cap_err(cap_err), .ind_err(ind_err), .load_err(load_err),
        .ctap_closed(ctap_closed), .ind_at_min(ind_at_min), .ind_at_six(ind_at_six),
        .ind_at_max(ind_at_max), .cap_at_min(cap_at_min), .cap_at_max(cap_at_max),
        .load_at_max(load_at_max), .tx_key(tx_key), .cap_unbal(cap_unbal),
        .err_line(err_line), .home_drive(home_drive), .load_brake(load_brake),
        .shunt_on(shunt_on), .ind_to_min(ind_to_min), .ind_to_max(ind_to_max),
        .ind_brake(ind_brake), .cap_to_min(cap_to_min), .cap_to_max(cap_to_max),
        .cap_brake(cap_brake));
    atrs_tuner_model i_atrs_tuner_model (
        .pclk(pclk), .presetn(presetn), .ind_to_min(ind_to_min), .ind_to_max(ind_to_max),
        .cap_to_min(cap_to_min), .cap_to_max(cap_to_max), .home_drive(home_drive),
        .ctap_closed(ctap_closed), .ind_at_min(ind_at_min), .ind_at_six(ind_at_six),
        .ind_at_max(ind_at_max), .cap_at_min(cap_at_min), .cap_at_max(cap_at_max),
        .load_at_max(load_at_max));
    // 200 MHz clock
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    function automatic logic exp_err(input logic [2:0] v);
        return v[0] | v[1] | v[2];
    endfunction
    task automatic end_of_test;
        if (err_total == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("MISMATCH at %0t: %s", $time, m);
        end
    endtask
    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            chk(1'b0, "bus hang");
            end_of_test;
        end
        rd = prdata;
        se = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    // Poll a status bit; polling bounds the wait
    task automatic wait_stat(input int b, input logic v);
        for (int n = 0; n < 1000; n++) begin
            apb(1'b0, 12'h004, 32'h0);
            if (rd[b] === v) return;
        end
        chk(1'b0, "status wait expired");
        end_of_test;
    endtask
    task automatic settle;
        repeat (6) @(posedge pclk);
    endtask
    task automatic pulse_retune;
        @(posedge pclk) retune_n <= 1'b0;
        repeat (4) @(posedge pclk);
        retune_n <= 1'b1;
    endtask
    initial begin
        void'($urandom(32'h5D60FEF5));
        err_total = 0; n_checks = 0;
        psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; presetn = 0;
        retune_n = 1; rf_present = 0; tx_key_req = 0; cap_err = 0; ind_err = 0; load_err = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h004, 32'h0); chk(rd === 32'h0, "status after reset");
        apb(1'b0, 12'h00C, 32'h0); chk(se === 1'b1, "unmapped read accepted");
        // Every error combination, then random ones
        for (int i = 0; i < 10; i++) begin
            e = (i < 8) ? 3'(i) : 3'($urandom);
            @(posedge pclk) {cap_err, ind_err, load_err} <= e;
            settle;
            chk(err_line === exp_err(e), "combined error");
            apb(1'b0, 12'h008, 32'h0); chk(rd[9:7] === e, "input mirror");
        end
        {cap_err, ind_err, load_err} <= 3'h0;
        apb(1'b1, 12'h000, 32'h4);
        // Full search cycle from a retune pulse
        rf_present <= 1'b1;
        pulse_retune;
        settle;
        apb(1'b0, 12'h004, 32'h0);
        chk(rd[2:0] === 3'h7 && rd[6] === 1'b0, "retune entry");
        chk(tx_key === 1'b1, "keying");
        chk(cap_unbal === 1'b1, "unbalance");
        chk(home_drive === 1'b1, "homing drive");
        rf_present <= 1'b0; load_err <= 1'b1;
        wait_stat(3, 1'b1);
        settle;
        apb(1'b0, 12'h004, 32'h0); chk(rd[0] === 1'b0, "retune release");
        chk(tx_key === 1'b1, "keying held");
        wait_stat(5, 1'b1);
        chk(cap_to_min === 1'b1, "capacitor to minimum");
        settle; chk(ind_brake === 1'b1 && ind_to_min === 1'b0, "brake");
        chk(load_brake === 1'b1, "loading brake");
        wait_stat(4, 1'b1);
        apb(1'b0, 12'h004, 32'h0); chk(rd[5] === 1'b0 && rd[3] === 1'b0, "min rev");
        chk(cap_brake === 1'b1, "capacitor brake");
        wait_stat(6, 1'b1);
        chk(shunt_on === 1'b1, "shunt output");
        wait_stat(3, 1'b1);
        ind_err <= 1'b1;
        settle; settle;
        apb(1'b0, 12'h004, 32'h0); chk(rd[3] === 1'b0, "max rev clear");
        chk(ind_to_min === 1'b1, "direction");
        ind_err <= 1'b0; load_err <= 1'b0;
        settle; settle;
        chk(tx_key === 1'b0, "unkey");
        // Tuning timeout with error never clearing
        load_err <= 1'b1;
        t0 = $time;
        pulse_retune;
        wait_stat(8, 1'b1);
        chk(($time - t0) >= 64'd10000, "timeout early");
        settle;
        chk({tx_key, ind_to_min, ind_to_max, cap_to_min, cap_to_max} === 5'h0, "drive");
        load_err <= 1'b0;
        apb(1'b1, 12'h000, 32'h4);
        apb(1'b0, 12'h004, 32'h0); chk(rd === 32'h0, "clear");
        // Radio silence: no keying until operator key, RF and error
        apb(1'b1, 12'h000, 32'h1);
        pulse_retune;
        settle;
        chk(tx_key === 1'b0, "silent keyed");
        tx_key_req <= 1'b1; rf_present <= 1'b1; load_err <= 1'b1;
        settle;
        chk(tx_key === 1'b1, "silent key");
        end_of_test;
    end
endmodule // tb_antenna_tuner_relay_sequencer
